// *** rtl/cmlro_pkg.sv ***
// constants and types shared by the move, logic and return execute block
`default_nettype none
package cmlro_pkg;
  localparam int CMLRO_DATA_W   = 8;
  localparam int CMLRO_ADDR_W   = 7;
  localparam int CMLRO_RF_DEPTH = 128;
  localparam int CMLRO_PC_W     = 13;
  localparam int CMLRO_STK_DEPTH = 8;
  localparam int CMLRO_SP_W     = 3;

  localparam logic [CMLRO_DATA_W-1:0] CMLRO_ACC_RST  = 8'h00;
  localparam logic [CMLRO_DATA_W-1:0] CMLRO_RF_RST   = 8'h00;
  localparam logic [CMLRO_PC_W-1:0]   CMLRO_PC_RST   = 13'h0000;
  localparam logic [CMLRO_PC_W-1:0]   CMLRO_PC_STEP  = 13'h0001;
  localparam logic [CMLRO_SP_W-1:0]   CMLRO_SP_RST   = 3'h0;
  localparam logic [CMLRO_SP_W-1:0]   CMLRO_SP_STEP  = 3'h1;
  localparam logic [CMLRO_DATA_W-1:0] CMLRO_ZERO_VAL = 8'h00;
  localparam int                      CMLRO_ROT_MSB  = 7;

  // destination select carried by register-file instructions
  localparam logic CMLRO_DEST_ACC = 1'b0;
  localparam logic CMLRO_DEST_REG = 1'b1;

  typedef enum logic [2:0] {
    CMLRO_OP_NO_OPERATION        = 3'h0,
    CMLRO_OP_OR_ACC_WITH_REG     = 3'h1,
    CMLRO_OP_MOVE_ACC_TO_REG     = 3'h2,
    CMLRO_OP_MOVE_REG_TO_DEST    = 3'h3,
    CMLRO_OP_ROTATE_RIGHT        = 3'h4,
    CMLRO_OP_RETURN_FROM_INT     = 3'h5,
    CMLRO_OP_RETURN_WITH_LITERAL = 3'h6,
    CMLRO_OP_RETURN_FROM_SUB     = 3'h7
  } cmlro_op_t;

  // one-hot sequencer: execute, or burn the second cycle of a return
  typedef enum logic [1:0] {
    CMLRO_ST_EXEC  = 2'b01,
    CMLRO_ST_FLUSH = 2'b10
  } cmlro_state_t;

  typedef struct packed {
    cmlro_state_t                                       st;
    logic [CMLRO_DATA_W-1:0]                            acc;
    logic                                               zero;
    logic                                               carry;
    logic                                               int_en;
    logic [CMLRO_PC_W-1:0]                              pc;
    logic [CMLRO_SP_W-1:0]                              sp;
    logic [CMLRO_STK_DEPTH-1:0][CMLRO_PC_W-1:0]         stk;
    logic [CMLRO_RF_DEPTH-1:0][CMLRO_DATA_W-1:0]        rf;
    logic [CMLRO_DATA_W-1:0]                            peek;
  } cmlro_regs_t;
endpackage
`default_nettype wire

// *** rtl/cmlro_alu.sv ***
// combinational datapath: result, write enables and flag updates per opcode
`default_nettype none
module cmlro_alu
  import cmlro_pkg::*;
(
  input  wire cmlro_op_t               op,
  input  wire logic                    dest,
  input  wire logic [CMLRO_DATA_W-1:0] acc,
  input  wire logic [CMLRO_DATA_W-1:0] fval,
  input  wire logic [CMLRO_DATA_W-1:0] lit,
  input  wire logic                    carry_in,
  output logic      [CMLRO_DATA_W-1:0] res,
  output logic                         wr_acc,
  output logic                         wr_reg,
  output logic                         zero_upd,
  output logic                         carry_upd,
  output logic                         carry_new
);
  logic to_reg;

  // destination bit steers the write of every dual-destination opcode
  assign to_reg = (dest == CMLRO_DEST_REG); // RL2

  always_comb begin
    res       = CMLRO_ZERO_VAL;
    wr_acc    = 1'b0;
    wr_reg    = 1'b0;
    zero_upd  = 1'b0;
    carry_upd = 1'b0;
    carry_new = carry_in;
    case (op)
      CMLRO_OP_OR_ACC_WITH_REG: begin
        res      = acc | fval; // RL1
        wr_acc   = !to_reg;
        wr_reg   = to_reg;
        zero_upd = 1'b1; // RL1
      end
      CMLRO_OP_MOVE_ACC_TO_REG: begin
        res    = acc; // RL3
        wr_reg = 1'b1;
      end
      CMLRO_OP_MOVE_REG_TO_DEST: begin
        res      = fval; // RL4
        wr_acc   = !to_reg;
        wr_reg   = to_reg;
        zero_upd = 1'b1; // RL5
      end
      CMLRO_OP_ROTATE_RIGHT: begin
        res       = {carry_in, fval[CMLRO_ROT_MSB:1]}; // RL10
        carry_new = fval[0]; // RL10
        carry_upd = 1'b1; // RL9
        wr_acc    = !to_reg;
        wr_reg    = to_reg;
      end
      CMLRO_OP_RETURN_WITH_LITERAL: begin
        res    = lit; // RL7
        wr_acc = 1'b1;
      end
      default: begin
        res = CMLRO_ZERO_VAL; // no data effect for no-op and plain returns
      end
    endcase
  end
endmodule
`default_nettype wire

// *** rtl/cmlro_core.sv ***
// execute unit for logic, move, rotate, no-op and stack return instructions
`default_nettype none
// How it works
// RL1: or accumulator with register, zero flag only
// RL2: destination bit zero accumulator, one register
// RL3: accumulator copied to register, flags untouched
// RL4: register value moved unchanged to destination
// RL5: register move sets zero from moved value
// RL6: interrupt return pops pc, sets interrupt enable
// RL7: literal return loads accumulator, pops, two cycles
// RL8: subroutine return pops pc, two cycles
// RL9: rotate right through carry, carry flag only
// RL10: old carry into bit seven, bit zero out
// RL11: no-op one cycle, only advances pc
module cmlro_core
  import cmlro_pkg::*;
(
  input  wire logic                    clk,
  input  wire logic                    resetn,
  input  wire logic                    ce,
  input  wire logic                    instr_valid,
  input  wire cmlro_op_t               instr_op,
  input  wire logic [CMLRO_ADDR_W-1:0] instr_addr,
  input  wire logic                    instr_dest,
  input  wire logic [CMLRO_DATA_W-1:0] instr_lit,
  output logic                         instr_ready,
  input  wire logic                    stack_push,
  input  wire logic [CMLRO_PC_W-1:0]   stack_push_pc,
  input  wire logic                    int_enable_clear,
  input  wire logic [CMLRO_ADDR_W-1:0] peek_addr,
  output logic      [CMLRO_DATA_W-1:0] peek_data,
  output logic      [CMLRO_DATA_W-1:0] acc,
  output logic                         zero_flag,
  output logic                         carry_flag,
  output logic                         global_interrupt_enable,
  output logic      [CMLRO_PC_W-1:0]   pc,
  output logic      [CMLRO_SP_W-1:0]   stack_depth,
  output logic      [CMLRO_PC_W-1:0]   stack_top_entry
);
  cmlro_regs_t             r_r;
  cmlro_regs_t             r_nxt;
  logic [CMLRO_DATA_W-1:0] fval;
  logic [CMLRO_DATA_W-1:0] res;
  logic                    wr_acc;
  logic                    wr_reg;
  logic                    zero_upd;
  logic                    carry_upd;
  logic                    carry_new;
  logic [CMLRO_SP_W-1:0]   sp_pop;
  logic                    take;
  logic                    is_return;

  // operand fetch and pop index; stack wraps like a ring of eight
  assign fval   = r_r.rf[instr_addr];
  assign sp_pop = r_r.sp - CMLRO_SP_STEP;

  // a pending push holds off new instructions so the two never collide
  assign instr_ready = (r_r.st == CMLRO_ST_EXEC) && !stack_push;
  assign take        = ce && instr_valid && instr_ready;
  assign is_return   = (instr_op == CMLRO_OP_RETURN_FROM_INT)
                    || (instr_op == CMLRO_OP_RETURN_WITH_LITERAL)
                    || (instr_op == CMLRO_OP_RETURN_FROM_SUB);

  cmlro_alu u_alu (
    .op        (instr_op),
    .dest      (instr_dest),
    .acc       (r_r.acc),
    .fval      (fval),
    .lit       (instr_lit),
    .carry_in  (r_r.carry),
    .res       (res),
    .wr_acc    (wr_acc),
    .wr_reg    (wr_reg),
    .zero_upd  (zero_upd),
    .carry_upd (carry_upd),
    .carry_new (carry_new)
  );

  // next-state: everything freezes while ce is low
  always_comb begin
    r_nxt = r_r;
    if (ce) begin
      r_nxt.peek = r_r.rf[peek_addr];
      case (r_r.st)
        CMLRO_ST_EXEC: begin
          if (stack_push) begin
            r_nxt.stk[r_r.sp] = stack_push_pc;
            r_nxt.sp          = r_r.sp + CMLRO_SP_STEP;
          end else if (instr_valid) begin
            if (wr_acc) begin
              r_nxt.acc = res; // RL2
            end
            if (wr_reg) begin
              r_nxt.rf[instr_addr] = res; // RL2
            end
            if (zero_upd) begin
              r_nxt.zero = (res == CMLRO_ZERO_VAL); // RL5
            end
            if (carry_upd) begin
              r_nxt.carry = carry_new; // RL9
            end
            if (is_return) begin
              r_nxt.sp = sp_pop; // RL8
              r_nxt.pc = r_r.stk[sp_pop]; // RL8
              r_nxt.st = CMLRO_ST_FLUSH; // RL7
            end else begin
              r_nxt.pc = r_r.pc + CMLRO_PC_STEP; // RL11
            end
          end
        end
        CMLRO_ST_FLUSH: begin
          r_nxt.st = CMLRO_ST_EXEC; // RL8
        end
        default: begin
          r_nxt.st = CMLRO_ST_EXEC;
        end
      endcase
      // the return's set beats an external clear in the same cycle
      if (int_enable_clear) begin
        r_nxt.int_en = 1'b0;
      end
      if (take && (instr_op == CMLRO_OP_RETURN_FROM_INT)) begin
        r_nxt.int_en = 1'b1; // RL6
      end
    end
  end

  // whole state in one register; register file is cleared at reset
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      r_r.st    <= CMLRO_ST_EXEC;
      r_r.acc   <= CMLRO_ACC_RST;
      r_r.zero  <= 1'b0;
      r_r.carry <= 1'b0;
      r_r.int_en <= 1'b0;
      r_r.pc    <= CMLRO_PC_RST;
      r_r.sp    <= CMLRO_SP_RST;
      r_r.stk   <= '0;
      r_r.rf    <= '0;
      r_r.peek  <= CMLRO_RF_RST;
    end else begin
      r_r <= r_nxt;
    end
  end

  // visible state straight from flops, except stack top, muxed from stk by sp_pop
  assign peek_data               = r_r.peek;
  assign acc                     = r_r.acc;
  assign zero_flag               = r_r.zero;
  assign carry_flag              = r_r.carry;
  assign global_interrupt_enable = r_r.int_en;
  assign pc                      = r_r.pc;
  assign stack_depth             = r_r.sp;
  assign stack_top_entry         = r_r.stk[sp_pop];
endmodule
`default_nettype wire

// *** tb/cmlro_chk.sv ***
// checker: flag, pc and timing relations of the execute block
`default_nettype none
module cmlro_chk
  import cmlro_pkg::*;
(
  input wire logic        clk,
  input wire logic        resetn,
  input wire logic        ce,
  input wire logic        instr_valid,
  input wire cmlro_op_t   instr_op,
  input wire logic        instr_dest,
  input wire logic [7:0]  instr_lit,
  input wire logic        instr_ready,
  input wire logic [7:0]  acc,
  input wire logic        zero_flag,
  input wire logic        carry_flag,
  input wire logic        global_interrupt_enable,
  input wire logic [12:0] pc,
  input wire logic [2:0]  stack_depth,
  input wire logic [12:0] stack_top_entry
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  logic tk;
  // an instruction is taken only with clock enable and ready
  assign tk = ce && instr_valid && instr_ready;
  chk_or_zero: assert property (tk && instr_op == CMLRO_OP_OR_ACC_WITH_REG
    && !instr_dest |=> zero_flag == (acc == 8'h00) && $stable(carry_flag))
    else $error("or flags wrong");
  chk_acc_move: assert property (tk && instr_op == CMLRO_OP_MOVE_ACC_TO_REG
    |=> $stable({acc, zero_flag, carry_flag})) else $error("acc move changed state");
  chk_move_zero: assert property (tk && instr_op == CMLRO_OP_MOVE_REG_TO_DEST && !instr_dest
    |=> zero_flag == (acc == 8'h00)) else $error("move zero flag wrong");
  chk_rot_zero: assert property (tk && instr_op == CMLRO_OP_ROTATE_RIGHT
    |=> $stable(zero_flag)) else $error("rotate touched zero");
  chk_int_return: assert property (tk && instr_op == CMLRO_OP_RETURN_FROM_INT
    |=> global_interrupt_enable && $stable(carry_flag)) else $error("interrupt return wrong");
  chk_lit_ret: assert property (tk && instr_op == CMLRO_OP_RETURN_WITH_LITERAL
    |=> acc == $past(instr_lit) && pc == $past(stack_top_entry))
    else $error("literal return wrong");
  chk_ret_flush: assert property (tk && instr_op >= CMLRO_OP_RETURN_FROM_INT
    |=> !instr_ready) else $error("return took one cycle");
  chk_sub_pop: assert property (tk && instr_op == CMLRO_OP_RETURN_FROM_SUB
    |=> pc == $past(stack_top_entry) && stack_depth == $past(stack_depth) - 3'h1)
    else $error("subroutine return wrong");
  chk_nop_pc: assert property (tk && instr_op == CMLRO_OP_NO_OPERATION
    |=> pc == $past(pc) + 13'h0001 && $stable(acc)) else $error("no-op wrong");
endmodule
bind cmlro_core cmlro_chk u_chk (
  .clk                     (clk),
  .resetn                  (resetn),
  .ce                      (ce),
  .instr_valid             (instr_valid),
  .instr_op                (instr_op),
  .instr_dest              (instr_dest),
  .instr_lit               (instr_lit),
  .instr_ready             (instr_ready),
  .acc                     (acc),
  .zero_flag               (zero_flag),
  .carry_flag              (carry_flag),
  .global_interrupt_enable (global_interrupt_enable),
  .pc                      (pc),
  .stack_depth             (stack_depth),
  .stack_top_entry         (stack_top_entry)
);
`default_nettype wire

// *** tb/cmlro_core_bench.sv ***
// random and directed bench for the execute block with a reference model
`default_nettype none
module cmlro_core_bench;
  import cmlro_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, resetn = 1'b0, ce = 1'b0, instr_valid = 1'b0, instr_dest = 1'b0;
  logic stack_push = 1'b0, int_enable_clear = 1'b0, instr_ready, zero_flag, carry_flag, w;
  logic global_interrupt_enable, m_z, m_c, m_g, m_fl;
  cmlro_op_t instr_op = CMLRO_OP_NO_OPERATION;
  logic [6:0] instr_addr = 7'h00, peek_addr = 7'h00;
  logic [7:0] instr_lit = 8'h00, peek_data, acc, m_acc, r, f, m_pk;
  logic [12:0] stack_push_pc = 13'h0000, pc, stack_top_entry, m_pc;
  logic [2:0] stack_depth, m_sp;
  logic [12:0] m_stk [8];
  logic [7:0] m_rf [128];
  int error_cnt = 0, comparisons = 0;
  cmlro_core DUT (
    .clk                     (clk),
    .resetn                  (resetn),
    .ce                      (ce),
    .instr_valid             (instr_valid),
    .instr_op                (instr_op),
    .instr_addr              (instr_addr),
    .instr_dest              (instr_dest),
    .instr_lit               (instr_lit),
    .instr_ready             (instr_ready),
    .stack_push              (stack_push),
    .stack_push_pc           (stack_push_pc),
    .int_enable_clear        (int_enable_clear),
    .peek_addr               (peek_addr),
    .peek_data               (peek_data),
    .acc                     (acc),
    .zero_flag               (zero_flag),
    .carry_flag              (carry_flag),
    .global_interrupt_enable (global_interrupt_enable),
    .pc                      (pc),
    .stack_depth             (stack_depth),
    .stack_top_entry         (stack_top_entry)
  );
  always #4 clk = ~clk;
  // reference step for the inputs sampled at this edge
  task automatic upd();
    if (ce) begin
      m_pk = m_rf[peek_addr];
      f = m_rf[instr_addr];
      w = 1'b0;
      if (int_enable_clear) m_g = 1'b0;
      if (stack_push) begin
        m_stk[m_sp] = stack_push_pc;
        m_sp = m_sp + 3'h1;
      end else if (m_fl) m_fl = 1'b0;
      else if (instr_valid) begin
        case (instr_op)
          CMLRO_OP_OR_ACC_WITH_REG: {w, r, m_z} = {1'b1, m_acc | f, (m_acc | f) == 8'h00};
          CMLRO_OP_MOVE_ACC_TO_REG: m_rf[instr_addr] = m_acc;
          CMLRO_OP_MOVE_REG_TO_DEST: {w, r, m_z} = {1'b1, f, f == 8'h00};
          CMLRO_OP_ROTATE_RIGHT: {w, r, m_c} = {1'b1, m_c, f};
          default: ;
        endcase
        if (w && instr_dest) m_rf[instr_addr] = r;
        else if (w) m_acc = r;
        if (instr_op >= CMLRO_OP_RETURN_FROM_INT) begin
          m_sp = m_sp - 3'h1;
          m_pc = m_stk[m_sp];
          m_fl = 1'b1;
          if (instr_op == CMLRO_OP_RETURN_WITH_LITERAL) m_acc = instr_lit;
          if (instr_op == CMLRO_OP_RETURN_FROM_INT) m_g = 1'b1;
        end else m_pc = m_pc + 13'h0001;
      end
    end
  endtask
  task automatic cmp(string n, logic [12:0] e, logic [12:0] g);
    comparisons++;
    if (g !== e) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  // low and top addresses so that reads hit earlier writes
  function automatic logic [6:0] ra();
    return 7'($urandom % 2 ? 120 + $urandom % 8 : $urandom % 8);
  endfunction
  // one cycle: model the edge, drive the next request, compare outputs
  task automatic step(cmlro_op_t o, logic [6:0] a, logic d, logic [7:0] l, logic p);
    @(posedge clk);
    upd();
    ce <= ($urandom % 8) != 0;
    instr_valid <= ($urandom % 8) != 0;
    instr_op <= o;
    instr_addr <= a;
    instr_dest <= d;
    instr_lit <= l;
    stack_push <= p && !m_fl;
    stack_push_pc <= 13'($urandom);
    int_enable_clear <= ($urandom % 16) == 0;
    peek_addr <= ra();
    #1;
    cmp("acc", 13'(m_acc), 13'(acc));
    cmp("zero", 13'(m_z), 13'(zero_flag));
    cmp("carry", 13'(m_c), 13'(carry_flag));
    cmp("int_en", 13'(m_g), 13'(global_interrupt_enable));
    cmp("pc", m_pc, pc);
    cmp("depth", 13'(m_sp), 13'(stack_depth));
    cmp("top", m_stk[m_sp - 3'h1], stack_top_entry);
    cmp("ready", 13'(!m_fl && !stack_push), 13'(instr_ready));
    cmp("peek", 13'(m_pk), 13'(peek_data));
  endtask
  task automatic results();
    if (error_cnt == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // reset, fill the stack past its depth, back-to-back returns, then random traffic
  initial begin
    void'($urandom(32'h52345866));
    {m_acc, m_z, m_c, m_g, m_fl, m_pc, m_sp, m_pk} = '0;
    m_stk = '{default: 13'h0000};
    m_rf = '{default: 8'h00};
    repeat (20) @(posedge clk);
    resetn <= 1'b1;
    for (int i = 0; i < 10; i++) step(CMLRO_OP_NO_OPERATION, 7'h7F, 1'b1, 8'hFF, 1'b1);
    for (int i = 0; i < 9; i++) begin
      step(cmlro_op_t'(3'(5 + i % 3)), 7'h00, 1'b0, 8'(i), 1'b0);
    end
    repeat (4000) begin
      step(cmlro_op_t'(3'($urandom)), ra(), 1'($urandom), 8'($urandom), $urandom % 6 == 0);
    end
    results();
  end
endmodule
`default_nettype wire
